// file: core/ucd_map.svh
// constants for the uart channel command decoder
`ifndef UCD_MAP_SVH
`define UCD_MAP_SVH
`define UCD_CMD_MSB 7
`define UCD_CMD_LSB 4
`define UCD_CMD_NONE 4'h0
`define UCD_CMD_MRPTR_FIRST 4'h1
`define UCD_CMD_RX_RESET 4'h2
`define UCD_CMD_TX_RESET 4'h3
`define UCD_CMD_ERR_RESET 4'h4
`define UCD_CMD_BRK_CHG_RESET 4'h5
`define UCD_CMD_BRK_START 4'h6
`define UCD_CMD_BRK_STOP 4'h7
`define UCD_CMD_RTS_ON 4'h8
`define UCD_CMD_RTS_OFF 4'h9
`define UCD_CMD_TMO_ON 4'ha
`define UCD_CMD_MRPTR_ZERO 4'hb
`define UCD_CMD_TMO_OFF 4'hc
`define UCD_CMD_UNUSED 4'hd
`define UCD_CMD_PD_ON 4'he
`define UCD_CMD_PD_OFF 4'hf
`define UCD_LOW_TXRX_OFF 4'ha
`define UCD_MRPTR_ZERO 2'h0
`define UCD_MRPTR_FIRST 2'h1
`define UCD_MRPTR_RST 2'h1
`define UCD_CMD_GAP 3
`define UCD_OSC_START_CYC 16
`endif

// file: core/ucd_pkg.sv
// types for the uart channel command decoder
package ucd_pkg;
   typedef logic [3:0] ucd_cmd_t;
   typedef logic [1:0] ucd_mrptr_t;
   typedef enum logic [1:0] {UCD_BRK_IDLE, UCD_BRK_WAIT, UCD_BRK_ON, UCD_BRK_MARK} ucd_brk_e;
endpackage : ucd_pkg

// file: core/ucd_if.sv
// command register link between host and decoder
`timescale 1ns/10ps
`default_nettype none
interface ucd_if;
   logic cmd_wr;
   logic [7:0] cmd_data;
   logic chan_a;
   modport dev (input cmd_wr, input cmd_data, input chan_a);
   modport host (output cmd_wr, output cmd_data, output chan_a);
endinterface : ucd_if
`default_nettype wire

// file: core/ucd_decoder.sv
// command decoder and executor for one uart channel
//
// Function
// - code 1 points mode pointer at first
// - code 2 resets receiver, flushes fifo
// - code 3 resets transmitter as hardware
// - code 4 clears status bits seven-four
// - code 5 clears break-change interrupt flag
// - code 6 drives serial output low
// - break waits until transmitter fully empty
// - break ignored unless transmitter enabled
// - code 7 marks one bit before next
// - codes 8/9 assert/negate request-to-send
// - time-out mode restarts timer per character
// - entering time-out stops counter, clears ready
// - code b sets mode pointer zero
// - code c returns timer control, nothing stopped
// - host stops counter after leaving time-out
// - code e stops oscillator, keeps registers
// - host sends only code f while down
// - host disables channel in the power-down write
// - power codes act on channel a only
// - code f restarts oscillator, leaves power-down
// - host waits for oscillator start-up
// - host spaces commands three clocks apart
`include "ucd_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ucd_decoder
   import ucd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ucd_if.dev cmd_if,
   input wire logic tx_enabled_i,
   input wire logic tx_busy_i,
   input wire logic bit_tick_i,
   input wire logic rx_char_loaded_i,
   input wire logic mode_reg_access_i,
   output logic [1:0] mode_reg_ptr_o,
   output logic rx_reset_o,
   output logic tx_reset_o,
   output logic err_status_clear_o,
   output logic brk_chg_clear_o,
   output logic serial_break_o,
   output logic tx_hold_o,
   output logic request_to_send_out_n_o,
   output logic timeout_mode_o,
   output logic ct_restart_o,
   output logic ct_stop_o,
   output logic ct_ready_clear_o,
   output logic ct_cmds_blocked_o,
   output logic osc_run_o,
   output logic osc_ready_o
);
   ucd_cmd_t cmd;
   logic exec;
   logic powered_down;
   ucd_brk_e brk_state;
   logic [1:0] bit_cnt;
   logic [4:0] osc_cnt;

   ////////////////////////////////////////////////////////////////
   assign cmd = cmd_if.cmd_data[`UCD_CMD_MSB:`UCD_CMD_LSB];
   // while down the clock is notionally stopped; only power-up acts
   assign exec = cmd_if.cmd_wr && (!powered_down || (cmd_if.chan_a && cmd == `UCD_CMD_PD_OFF));

   function automatic logic is_cmd(input ucd_cmd_t c, input ucd_cmd_t want);
      is_cmd = (c == want);
   endfunction : is_cmd

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_reg_ptr_o <= `UCD_MRPTR_RST;
      end else if (exec && is_cmd(cmd, `UCD_CMD_MRPTR_FIRST)) begin
         mode_reg_ptr_o <= `UCD_MRPTR_FIRST;
      end else if (exec && is_cmd(cmd, `UCD_CMD_MRPTR_ZERO)) begin
         mode_reg_ptr_o <= `UCD_MRPTR_ZERO;
      end else if (!powered_down && mode_reg_access_i && mode_reg_ptr_o != 2'h3) begin
         mode_reg_ptr_o <= mode_reg_ptr_o + 2'h1;
      end
   end

   // one-cycle action pulses
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_reset_o <= 1'b0;
         tx_reset_o <= 1'b0;
         err_status_clear_o <= 1'b0;
         brk_chg_clear_o <= 1'b0;
         ct_stop_o <= 1'b0;
         ct_ready_clear_o <= 1'b0;
      end else begin
         rx_reset_o <= exec && is_cmd(cmd, `UCD_CMD_RX_RESET);
         tx_reset_o <= exec && is_cmd(cmd, `UCD_CMD_TX_RESET);
         err_status_clear_o <= exec && is_cmd(cmd, `UCD_CMD_ERR_RESET);
         brk_chg_clear_o <= exec && is_cmd(cmd, `UCD_CMD_BRK_CHG_RESET);
         ct_stop_o <= exec && is_cmd(cmd, `UCD_CMD_TMO_ON);
         ct_ready_clear_o <= exec && is_cmd(cmd, `UCD_CMD_TMO_ON);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         request_to_send_out_n_o <= 1'b1;
      end else if (exec && is_cmd(cmd, `UCD_CMD_RTS_ON)) begin
         request_to_send_out_n_o <= 1'b0;
      end else if (exec && is_cmd(cmd, `UCD_CMD_RTS_OFF)) begin
         request_to_send_out_n_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timeout_mode_o <= 1'b0;
      end else if (exec && is_cmd(cmd, `UCD_CMD_TMO_ON)) begin
         timeout_mode_o <= 1'b1;
      end else if (exec && is_cmd(cmd, `UCD_CMD_TMO_OFF)) begin
         timeout_mode_o <= 1'b0;
      end
   end
   assign ct_cmds_blocked_o = timeout_mode_o;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ct_restart_o <= 1'b0;
      end else begin
         ct_restart_o <= timeout_mode_o && rx_char_loaded_i && !powered_down;
      end
   end

   ////////////////////////////////////////////////////////////////
   // break sequencer; bit_cnt counts the two bit ticks of the one-bit mark
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         brk_state <= UCD_BRK_IDLE;
         bit_cnt <= 2'h0;
      end else if (exec && is_cmd(cmd, `UCD_CMD_TX_RESET)) begin
         brk_state <= UCD_BRK_IDLE;
         bit_cnt <= 2'h0;
      end else if (!powered_down) begin
         case (brk_state)
            UCD_BRK_IDLE: begin
               if (exec && is_cmd(cmd, `UCD_CMD_BRK_START) && tx_enabled_i) begin
                  brk_state <= UCD_BRK_WAIT;
               end
            end
            UCD_BRK_WAIT: begin
               if (exec && is_cmd(cmd, `UCD_CMD_BRK_STOP)) begin
                  brk_state <= UCD_BRK_IDLE;
               end else if (!tx_busy_i) begin
                  brk_state <= UCD_BRK_ON;
               end
            end
            UCD_BRK_ON: begin
               if (exec && is_cmd(cmd, `UCD_CMD_BRK_STOP)) begin
                  brk_state <= UCD_BRK_MARK;
                  bit_cnt <= 2'h0;
               end
            end
            UCD_BRK_MARK: begin
               // first tick may come early, so a whole bit time needs two
               if (bit_tick_i) begin
                  if (bit_cnt == 2'h1) begin
                     brk_state <= UCD_BRK_IDLE;
                  end else begin
                     bit_cnt <= bit_cnt + 2'h1;
                  end
               end
            end
            default: begin
               brk_state <= UCD_BRK_IDLE;
            end
         endcase
      end
   end
   assign serial_break_o = (brk_state == UCD_BRK_ON);
   // transmitter holds new characters while a break is active or marking
   assign tx_hold_o = (brk_state == UCD_BRK_ON) || (brk_state == UCD_BRK_MARK);

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         powered_down <= 1'b0;
      end else if (exec && cmd_if.chan_a && is_cmd(cmd, `UCD_CMD_PD_ON)) begin
         powered_down <= 1'b1;
      end else if (exec && cmd_if.chan_a && is_cmd(cmd, `UCD_CMD_PD_OFF)) begin
         powered_down <= 1'b0;
      end
   end
   assign osc_run_o = !powered_down;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         osc_cnt <= 5'h0;
      end else if (powered_down) begin
         osc_cnt <= 5'h0;
      end else if (osc_cnt != 5'(`UCD_OSC_START_CYC)) begin
         osc_cnt <= osc_cnt + 5'h1;
      end
   end
   assign osc_ready_o = (osc_cnt == 5'(`UCD_OSC_START_CYC));
   // codes 0 and d fall through every decode above untouched
endmodule : ucd_decoder
`default_nettype wire

// file: core/ucd_host.sv
// host end that writes commands into the channel command register
`include "ucd_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ucd_host
   import ucd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ucd_if.host cmd_if,
   input wire logic req_valid_i,
   input wire logic [3:0] req_cmd_i,
   input wire logic [3:0] req_low_i,
   input wire logic req_chan_a_i,
   input wire logic osc_ready_i,
   output logic req_ready_o,
   output logic powered_down_o
);
   logic [1:0] gap_cnt;
   logic down;
   logic allowed;

   ////////////////////////////////////////////////////////////////
   // power-down legal only on channel a, and only code f while down
   assign allowed = down ? (req_chan_a_i && req_cmd_i == `UCD_CMD_PD_OFF) :
                    (req_chan_a_i || (req_cmd_i != `UCD_CMD_PD_ON && req_cmd_i != `UCD_CMD_PD_OFF));
   assign req_ready_o = (gap_cnt == 2'h0) && (down || osc_ready_i) && allowed;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_if.cmd_wr <= 1'b0;
         cmd_if.cmd_data <= 8'h00;
         cmd_if.chan_a <= 1'b0;
         gap_cnt <= 2'h0;
      end else begin
         cmd_if.cmd_wr <= req_valid_i && req_ready_o;
         if (req_valid_i && req_ready_o) begin
            // power-down also switches both directions off in the same write
            cmd_if.cmd_data <= {req_cmd_i, (req_cmd_i == `UCD_CMD_PD_ON) ? `UCD_LOW_TXRX_OFF : req_low_i};
            cmd_if.chan_a <= req_chan_a_i;
            gap_cnt <= 2'(`UCD_CMD_GAP - 1);
         end else if (gap_cnt != 2'h0) begin
            gap_cnt <= gap_cnt - 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         down <= 1'b0;
      end else if (req_valid_i && req_ready_o && req_chan_a_i) begin
         if (req_cmd_i == `UCD_CMD_PD_ON) begin
            down <= 1'b1;
         end else if (req_cmd_i == `UCD_CMD_PD_OFF) begin
            down <= 1'b0;
         end
      end
   end
   assign powered_down_o = down;
   // stop-counter lives outside this link; the user driving req_* issues it
endmodule : ucd_host
`default_nettype wire

// file: test/ucd_link_asserts.sv
// assertions on the command link and decoder outputs
`timescale 1ns/10ps
`default_nettype none
module ucd_link_asserts (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_data,
   input wire logic chan_a,
   input wire logic rx_reset_o,
   input wire logic tx_reset_o,
   input wire logic request_to_send_out_n_o,
   input wire logic err_status_clear_o,
   input wire logic brk_chg_clear_o,
   input wire logic serial_break_o,
   input wire logic tx_hold_o,
   input wire logic tx_busy_i,
   input wire logic [1:0] mode_reg_ptr_o,
   input wire logic timeout_mode_o,
   input wire logic ct_restart_o,
   input wire logic ct_stop_o,
   input wire logic rx_char_loaded_i,
   input wire logic osc_run_o
);
   // a write only counts while the oscillator runs
   wire logic tk = cmd_wr & osc_run_o;
   wire logic [3:0] code = cmd_data[7:4];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////////////////////////
   chk_rx_reset_pulse: assert property (tk && code == 4'h2 |=> rx_reset_o)
      else $error("rx reset pulse missing");
   chk_tx_reset_pulse: assert property (tk && code == 4'h3 |=> tx_reset_o)
      else $error("tx reset pulse missing");
   chk_err_clear_pulse: assert property (tk && code == 4'h4 |=> err_status_clear_o)
      else $error("error clear pulse missing");
   chk_brk_chg_pulse: assert property (tk && code == 4'h5 |=> brk_chg_clear_o)
      else $error("break change clear missing");
   chk_rts_assert: assert property (tk && code == 4'h8 |=> !request_to_send_out_n_o)
      else $error("rts not asserted");
   chk_rts_negate: assert property (tk && code == 4'h9 |=> request_to_send_out_n_o)
      else $error("rts not negated");
   chk_ptr_to_first: assert property (tk && code == 4'h1 |=> mode_reg_ptr_o == 2'h1)
      else $error("mode pointer not first");
   chk_timeout_leave: assert property (tk && code == 4'hc |=> !timeout_mode_o && !ct_stop_o)
      else $error("timeout exit wrong");
   chk_break_after_idle: assert property ($rose(serial_break_o) |-> !$past(tx_busy_i))
      else $error("break began while transmitter busy");
   chk_mark_hold: assert property ($fell(serial_break_o) && !tx_reset_o |-> tx_hold_o)
      else $error("no marking hold after break");
   chk_pd_stops: assert property (tk && chan_a && code == 4'he |=> !osc_run_o)
      else $error("power-down did not stop oscillator");
   chk_host_pd_chan: assert property (cmd_wr && (code == 4'he || code == 4'hf) |-> chan_a)
      else $error("power code sent to channel b");
   chk_host_gap: assert property (cmd_wr |=> !cmd_wr ##1 !cmd_wr)
      else $error("commands closer than gap");
   chk_ptr_to_zero: assert property (tk && code == 4'hb |=> mode_reg_ptr_o == 2'h0)
      else $error("mode pointer not zero");
   chk_timeout_enter: assert property (tk && code == 4'ha |=> timeout_mode_o && ct_stop_o)
      else $error("timeout entry wrong");
   chk_timeout_restart: assert property (osc_run_o && timeout_mode_o && rx_char_loaded_i |=> ct_restart_o)
      else $error("timer restart missing");
   chk_pd_chan_b: assert property (tk && !chan_a && code == 4'he |=> osc_run_o)
      else $error("channel b stopped oscillator");
   chk_noop_stable: assert property (tk && (code == 4'h0 || code == 4'hd)
      |=> $stable(request_to_send_out_n_o) && $stable(timeout_mode_o))
      else $error("no-op changed state");
   cover property (tk && code == 4'h6);
   cover property (ct_restart_o);
   cover property (!osc_run_o);
   cover property ($fell(tx_hold_o));
endmodule : ucd_link_asserts
`default_nettype wire

// file: test/tb_uart_channel_command_decoder.sv
// testbench for the command decoder and its host end
`timescale 1ns/10ps
`default_nettype none
module tb_uart_channel_command_decoder;
   import ucd_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic req_chan_a_i = 1'b1;
   logic [3:0] req_cmd_i = 4'h0;
   logic tx_enabled_i = 1'b0;
   logic tx_busy_i = 1'b0;
   logic bit_tick_i = 1'b0;
   logic rx_char_loaded_i = 1'b0;
   logic mode_reg_access_i = 1'b0;
   logic req_ready_o, powered_down_o, rx_reset_o, tx_reset_o, err_status_clear_o, brk_chg_clear_o;
   logic serial_break_o, tx_hold_o, request_to_send_out_n_o, timeout_mode_o, ct_restart_o, ct_stop_o;
   logic ct_ready_clear_o, ct_cmds_blocked_o, osc_run_o, osc_ready_o;
   logic [1:0] mode_reg_ptr_o;
   int n_errors = 0;
   int n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   ucd_if link();
   ucd_decoder ucd_decoder_i (.clk_i, .rst_b_i, .cmd_if(link), .tx_enabled_i, .tx_busy_i, .bit_tick_i,
      .rx_char_loaded_i, .mode_reg_access_i, .mode_reg_ptr_o, .rx_reset_o, .tx_reset_o,
      .err_status_clear_o, .brk_chg_clear_o, .serial_break_o, .tx_hold_o, .request_to_send_out_n_o,
      .timeout_mode_o, .ct_restart_o, .ct_stop_o, .ct_ready_clear_o, .ct_cmds_blocked_o, .osc_run_o, .osc_ready_o);
   ucd_host ucd_host_i (.clk_i, .rst_b_i, .cmd_if(link), .req_valid_i, .req_cmd_i, .req_low_i(4'h0),
      .req_chan_a_i, .osc_ready_i(osc_ready_o), .req_ready_o, .powered_down_o);
   ucd_link_asserts ucd_link_asserts_i (.clk_i, .rst_b_i, .cmd_wr(link.cmd_wr), .cmd_data(link.cmd_data),
      .chan_a(link.chan_a), .rx_reset_o, .tx_reset_o, .request_to_send_out_n_o, .err_status_clear_o,
      .brk_chg_clear_o, .serial_break_o, .tx_hold_o, .tx_busy_i, .mode_reg_ptr_o,
      .timeout_mode_o, .ct_restart_o, .ct_stop_o, .rx_char_loaded_i, .osc_run_o);
   ////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task ticks(input int n);
      repeat (n) @(negedge clk_i);
   endtask : ticks
   // waits are bounded so a stuck handshake still reaches the report
   // osc high waits for the oscillator, low for the host's ready
   task wait_ready(input logic osc);
      int k;
      k = 0;
      while (((osc ? osc_ready_o : req_ready_o) !== 1'b1) && k < 100) begin
         @(negedge clk_i);
         k++;
      end
      if (k == 100) begin
         chk(8'h0, 8'h1);
         results();
      end
   endtask : wait_ready
   // ends at the falling edge where the decoder's answer stands
   // ready depends on the code, so the code is set a cycle before it is judged
   task send(input logic [3:0] c, input logic a);
      req_cmd_i = c;
      req_chan_a_i = a;
      ticks(1);
      wait_ready(1'b0);
      req_valid_i = 1'b1;
      ticks(1);
      req_valid_i = 1'b0;
      ticks(1);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ticks(10);
      rst_b_i = 1'b1;
      wait_ready(1'b1);
      for (int i = 0; i < 2; i++) begin
         send(4'h2 + 4'(i), 1'b1);
         chk({rx_reset_o, tx_reset_o}, 8'h2 >> i);
         send(4'h4 + 4'(i), 1'b1);
         chk({err_status_clear_o, brk_chg_clear_o}, 8'h2 >> i);
      end
      $display("test pulses done");
      send(4'h8, 1'b1);
      chk(request_to_send_out_n_o, 8'h0);
      send(4'h9, 1'b1);
      chk(request_to_send_out_n_o, 8'h1);
      send(4'h0, 1'b1);
      send(4'hd, 1'b1);
      chk({request_to_send_out_n_o, timeout_mode_o, mode_reg_ptr_o}, 8'h9);
      send(4'hb, 1'b1);
      chk(mode_reg_ptr_o, 8'h0);
      send(4'h1, 1'b1);
      chk(mode_reg_ptr_o, 8'h1);
      mode_reg_access_i = 1'b1;
      ticks(1);
      mode_reg_access_i = 1'b0;
      chk(mode_reg_ptr_o, 8'h2);
      send(4'h1, 1'b1);
      chk(mode_reg_ptr_o, 8'h1);
      $display("test levels done");
      send(4'ha, 1'b1);
      chk({timeout_mode_o, ct_stop_o, ct_ready_clear_o, ct_cmds_blocked_o}, 8'hf);
      rx_char_loaded_i = 1'b1;
      ticks(1);
      rx_char_loaded_i = 1'b0;
      chk(ct_restart_o, 8'h1);
      send(4'hc, 1'b1);
      chk({timeout_mode_o, ct_stop_o, ct_ready_clear_o}, 8'h0);
      $display("test timeout done");
      send(4'h6, 1'b1);
      ticks(4);
      chk(serial_break_o, 8'h0);
      tx_enabled_i = 1'b1;
      tx_busy_i = 1'b1;
      send(4'h6, 1'b1);
      ticks(4);
      chk(serial_break_o, 8'h0);
      tx_busy_i = 1'b0;
      ticks(3);
      chk(serial_break_o, 8'h1);
      send(4'h7, 1'b1);
      chk({serial_break_o, tx_hold_o}, 8'h1);
      bit_tick_i = 1'b1;
      ticks(1);
      bit_tick_i = 1'b0;
      chk({serial_break_o, tx_hold_o}, 8'h1);
      bit_tick_i = 1'b1;
      ticks(1);
      bit_tick_i = 1'b0;
      chk({serial_break_o, tx_hold_o}, 8'h0);
      $display("test break done");
      req_cmd_i = 4'he;
      req_chan_a_i = 1'b0;
      req_valid_i = 1'b1;
      ticks(3);
      chk(req_ready_o, 8'h0);
      chk(osc_run_o, 8'h1);
      req_valid_i = 1'b0;
      send(4'he, 1'b1);
      chk({osc_run_o, powered_down_o}, 8'h1);
      chk(link.cmd_data, 8'hea);
      req_cmd_i = 4'h8;
      req_valid_i = 1'b1;
      ticks(3);
      chk(req_ready_o, 8'h0);
      chk(request_to_send_out_n_o, 8'h1);
      req_valid_i = 1'b0;
      send(4'hf, 1'b1);
      chk(osc_run_o, 8'h1);
      ticks(1);
      chk(req_ready_o, 8'h0);
      wait_ready(1'b1);
      chk({request_to_send_out_n_o, mode_reg_ptr_o}, 8'h5);
      $display("test power done");
      results();
   end
endmodule : tb_uart_channel_command_decoder
`default_nettype wire
